/* pkg/ars_pkg.sv */
// Package for the automatic restart supervisor: register map, resets, timing constants
`default_nettype none
package ars_pkg;
  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned TICK_PERIOD_S      = 1;
  localparam int unsigned TICK_CYCLES        = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned TICK_CYCLES_SIM    = TICK_CYCLES;

  localparam logic [7:0]  RST_MON_TIME       = 8'h3c;
  localparam logic [7:0]  RST_WIN_TIME       = 8'h00;
  localparam logic [7:0]  RST_MAX_ATTEMPTS   = 8'h03;
  localparam logic [7:0]  RST_MODE           = 8'h00;

  localparam logic [7:0]  MODE_4             = 8'h04;
  localparam logic [7:0]  MODE_6             = 8'h06;
  localparam logic [7:0]  MODE_14            = 8'h0e;
  localparam logic [7:0]  MODE_16            = 8'h10;
  localparam logic [7:0]  MODE_26            = 8'h1a;

  localparam int unsigned SUPPRESS_ENTRIES   = 10;
  localparam int unsigned FAULT_NUM_W        = 16;

  // Word offsets (byte address = 4 * index)
  localparam logic [4:0]  IDX_CTRL           = 5'h00;
  localparam logic [4:0]  IDX_MON_TIME       = 5'h01;
  localparam logic [4:0]  IDX_WIN_TIME       = 5'h02;
  localparam logic [4:0]  IDX_MAX_ATT        = 5'h03;
  localparam logic [4:0]  IDX_STATUS         = 5'h04;
  localparam logic [4:0]  IDX_IRQ_STAT       = 5'h05;
  localparam logic [4:0]  IDX_IRQ_MASK       = 5'h06;
  localparam logic [4:0]  IDX_LIST0          = 5'h08;

  // Interrupt status bits
  localparam int unsigned IRQ_FAIL_BIT       = 0;
  localparam int unsigned IRQ_START_BIT      = 1;
  localparam int unsigned IRQ_W              = 2;

  typedef enum logic [1:0] {
    ARS_IDLE    = 2'b00,
    ARS_RESTART = 2'b01,
    ARS_RUN     = 2'b10,
    ARS_HALT    = 2'b11
  } ars_state_e;
endpackage
`default_nettype wire

/* rtl/ars_sec_timer.sv */
// Seconds down-counter with start, stop and expiry pulse
`default_nettype none
module ars_sec_timer (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [7:0] load_val,
  // Status
  output logic            running,
  output logic            expired
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       run_q;
  logic       run_d;
  logic       exp_q;
  logic       exp_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (stop) begin
      run_d = 1'b0;
    end else if (start) begin
      cnt_d = load_val;
      run_d = (load_val != 8'h00);
    end else if (run_q && tick) begin
      if (cnt_q <= 8'h01) begin
        run_d = 1'b0;
        exp_d = 1'b1;
        cnt_d = 8'h00;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign running = run_q;
  assign expired = exp_q;
endmodule
`default_nettype wire

/* rtl/ars_supervisor.sv */
// Automatic restart supervisor with Avalon-MM registers and interrupt
`default_nettype none
module ars_supervisor
  import ars_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = ars_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  // Avalon-MM slave
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // Converter side
  input  wire logic                   fault_detect,
  input  wire logic [ars_pkg::FAULT_NUM_W-1:0] fault_number,
  input  wire logic                   fault_ack,
  input  wire logic                   start_success,
  input  wire logic                   run_command,
  // Results
  output logic                        restart_request,
  output logic                        restart_failed_fault,
  output logic                        irq
);
  import ars_pkg::*;

  // Refuse a prescaler too short to count whole seconds
  if (TICK_CYCLES_P < 2) begin : g_bad_tick
    $error("ars_supervisor: TICK_CYCLES_P too small");
  end

  // Refuse a suppression list that runs past the top of the word map
  if (32'(IDX_LIST0) + SUPPRESS_ENTRIES > 32) begin : g_bad_map
    $error("ars_supervisor: suppression list does not fit the address map");
  end

  // Configuration registers
  logic [7:0]             mode_q;
  logic [7:0]             mode_d;
  logic [7:0]             mon_time_q;
  logic [7:0]             mon_time_d;
  logic [7:0]             win_time_q;
  logic [7:0]             win_time_d;
  logic [7:0]             max_att_q;
  logic [7:0]             max_att_d;
  logic [FAULT_NUM_W-1:0] list_q [SUPPRESS_ENTRIES];
  logic [FAULT_NUM_W-1:0] list_d [SUPPRESS_ENTRIES];
  logic [IRQ_W-1:0]       ist_q;
  logic [IRQ_W-1:0]       ist_d;
  logic [IRQ_W-1:0]       imask_q;
  logic [IRQ_W-1:0]       imask_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   wait_q;
  logic                   wait_d;

  // Supervision state
  ars_state_e             st_q;
  ars_state_e             st_d;
  logic [7:0]             att_q;
  logic [7:0]             att_d;
  logic [7:0]             starts_q;
  logic [7:0]             starts_d;
  logic                   fail_q;
  logic                   fail_d;
  logic                   req_q;
  logic                   req_d;
  logic                   irq_q;
  logic                   irq_d;
  logic                   supp_q;
  logic                   supp_d;

  // Timer handshakes and decodes
  logic                   tick;
  logic                   mon_run;
  logic                   mon_exp;
  logic                   win_run;
  logic                   win_exp;
  logic                   mon_start;
  logic                   mon_stop;
  logic                   win_start;
  logic                   win_stop;
  logic                   timers_on;
  logic                   supp_on;
  logic                   match;
  logic                   cfg_change;
  logic                   acc;
  logic                   wr;
  logic                   rd;
  logic [SUPPRESS_ENTRIES-1:0] hit;

  function automatic logic mode_timed(input logic [7:0] m);
    return (m == MODE_4) || (m == MODE_6) || (m == MODE_14) ||
           (m == MODE_16) || (m == MODE_26);
  endfunction

  function automatic logic mode_list(input logic [7:0] m);
    return (m == MODE_6) || (m == MODE_16) || (m == MODE_26);
  endfunction

  // Suppression list slot that a bus word index selects
  function automatic logic list_sel(input logic [4:0] a, input int i);
    return a == (IDX_LIST0 + 5'(i));
  endfunction

  // Both timers share one prescaler so their seconds stay aligned
  ars_tick #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (tick)
  );

  ars_sec_timer u_mon (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .tick     (tick),
    .start    (mon_start),
    .stop     (mon_stop),
    .load_val (mon_time_q),
    .running  (mon_run),
    .expired  (mon_exp)
  );

  ars_sec_timer u_win (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .tick     (tick),
    .start    (win_start),
    .stop     (win_stop),
    .load_val (win_time_q),
    .running  (win_run),
    .expired  (win_exp)
  );

  assign timers_on = mode_timed(mode_q);
  assign supp_on   = mode_list(mode_q);

  // Fault number compare against every suppression entry, one comparator per slot.
  // A cleared slot holds zero, so in the list modes (MODE_6, MODE_16, MODE_26) fault number zero is suppressed by default.
  for (genvar g = 0; g < SUPPRESS_ENTRIES; g++) begin : g_cmp
    assign hit[g] = (list_q[g] == fault_number);
  end
  assign match = |hit;

  // One wait cycle per access: waitrequest rests high and drops only for the cycle after a request is seen
  assign acc = (avs_read || avs_write) && wait_q;
  assign wr  = avs_write && wait_q;
  assign rd  = avs_read && wait_q;
  assign cfg_change = wr && ((avs_address == IDX_CTRL) || (avs_address == IDX_MAX_ATT));

  // Register file
  always_comb begin
    mode_d     = mode_q;
    mon_time_d = mon_time_q;
    win_time_d = win_time_q;
    max_att_d  = max_att_q;
    imask_d    = imask_q;
    list_d     = list_q;
    rdata_d    = rdata_q;
    wait_d     = !acc;
    // Unmapped words read zero and ignore writes
    if (wr) begin
      unique case (avs_address)
        IDX_CTRL:     mode_d     = avs_writedata[7:0];
        IDX_MON_TIME: mon_time_d = avs_writedata[7:0];
        IDX_WIN_TIME: win_time_d = avs_writedata[7:0];
        IDX_MAX_ATT:  max_att_d  = avs_writedata[7:0];
        IDX_IRQ_MASK: imask_d    = avs_writedata[IRQ_W-1:0];
        default: begin
          for (int i = 0; i < SUPPRESS_ENTRIES; i++) begin
            if (list_sel(avs_address, i)) list_d[i] = avs_writedata[FAULT_NUM_W-1:0];
          end
        end
      endcase
    end
    if (rd) begin
      rdata_d = 32'h0;
      unique case (avs_address)
        IDX_CTRL:     rdata_d[7:0] = mode_q;
        IDX_MON_TIME: rdata_d[7:0] = mon_time_q;
        IDX_WIN_TIME: rdata_d[7:0] = win_time_q;
        IDX_MAX_ATT:  rdata_d[7:0] = max_att_q;
        IDX_STATUS: begin
          rdata_d[1:0]   = st_q;
          rdata_d[2]     = req_q;
          rdata_d[3]     = fail_q;
          rdata_d[4]     = mon_run;
          rdata_d[5]     = win_run;
          rdata_d[13:6]  = starts_q;
          rdata_d[21:14] = att_q;
        end
        IDX_IRQ_STAT: rdata_d[IRQ_W-1:0] = ist_q;
        IDX_IRQ_MASK: rdata_d[IRQ_W-1:0] = imask_q;
        default: begin
          for (int i = 0; i < SUPPRESS_ENTRIES; i++) begin
            if (list_sel(avs_address, i)) rdata_d[FAULT_NUM_W-1:0] = list_q[i];
          end
        end
      endcase
    end
  end

  // Restart sequence
  always_comb begin
    st_d      = st_q;
    att_d     = att_q;
    starts_d  = starts_q;
    fail_d    = fail_q;
    req_d     = 1'b0;
    supp_d    = supp_q;
    mon_start = 1'b0;
    mon_stop  = 1'b0;
    win_start = 1'b0;
    win_stop  = !timers_on;
    // Reload from the value being written, not the one it replaces
    if (cfg_change) begin
      att_d = max_att_d;
    end
    if (win_exp) begin
      att_d    = max_att_q;
      starts_d = 8'h00;
    end
    unique case (st_q)
      ARS_IDLE, ARS_RUN: begin
        if (fault_detect && mode_q != RST_MODE) begin
          st_d   = ARS_RESTART;
          supp_d = supp_on && match;
          mon_start = timers_on && (mon_time_q != 8'h00);
        end
      end
      ARS_RESTART: begin
        // In timed modes the acknowledge that would spend the last attempt halts instead
        if (fault_ack && !supp_q) begin
          if (att_q > 8'h01) begin
            att_d = att_q - 8'h01;
            req_d = 1'b1;
          end else if (timers_on) begin
            st_d   = ARS_HALT;
            fail_d = 1'b1;
          end else begin
            req_d = 1'b1;
          end
        end
        // Starts accumulate only while the window is open; outside it a start resets the count to one
        if (start_success) begin
          mon_stop  = 1'b1;
          win_start = timers_on && (win_time_q != 8'h00);
          starts_d  = (win_run ? starts_q : 8'h00) + 8'h01;
          st_d      = ARS_RUN;
          if (timers_on && win_run && (starts_q + 8'h01 > max_att_q)) begin
            st_d   = ARS_HALT;
            fail_d = 1'b1;
          end
        end else if (mon_exp && timers_on) begin
          st_d   = ARS_HALT;
          fail_d = 1'b1;
        end
      end
      ARS_HALT: begin
        // Leaving needs the run command off, so the motor cannot start unasked
        mon_stop = 1'b1;
        win_stop = 1'b1;
        if (fault_ack && !run_command) begin
          fail_d   = 1'b0;
          att_d    = max_att_q;
          starts_d = 8'h00;
          st_d     = ARS_IDLE;
        end
      end
    endcase
  end

  // Interrupts: hardware set wins over software clear
  always_comb begin
    ist_d = ist_q;
    if (wr && avs_address == IDX_IRQ_STAT) ist_d = ist_q & ~avs_writedata[IRQ_W-1:0];
    if (fail_d && !fail_q) ist_d[IRQ_FAIL_BIT] = 1'b1;
    if (req_d) ist_d[IRQ_START_BIT] = 1'b1;
    // Built from next values so irq lands with the flag, not a cycle later
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_q     <= RST_MODE;
      mon_time_q <= RST_MON_TIME;
      win_time_q <= RST_WIN_TIME;
      max_att_q  <= RST_MAX_ATTEMPTS;
      imask_q    <= '0;
      ist_q      <= '0;
      for (int i = 0; i < SUPPRESS_ENTRIES; i++) list_q[i] <= '0;
      rdata_q    <= 32'h0;
      wait_q     <= 1'b1;
      st_q       <= ARS_IDLE;
      att_q      <= RST_MAX_ATTEMPTS;
      starts_q   <= 8'h00;
      fail_q     <= 1'b0;
      req_q      <= 1'b0;
      irq_q      <= 1'b0;
      supp_q     <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      mon_time_q <= mon_time_d;
      win_time_q <= win_time_d;
      max_att_q  <= max_att_d;
      imask_q    <= imask_d;
      ist_q      <= ist_d;
      list_q     <= list_d;
      rdata_q    <= rdata_d;
      wait_q     <= wait_d;
      st_q       <= st_d;
      att_q      <= att_d;
      starts_q   <= starts_d;
      fail_q     <= fail_d;
      req_q      <= req_d;
      irq_q      <= irq_d;
      supp_q     <= supp_d;
    end
  end

  assign avs_readdata         = rdata_q;
  assign avs_waitrequest      = wait_q;
  assign restart_request      = req_q;
  assign restart_failed_fault = fail_q;
  assign irq                  = irq_q;
endmodule
`default_nettype wire

/* rtl/ars_tick.sv */
// One-second tick prescaler from the system clock
`default_nettype none
module ars_tick #(
  parameter int unsigned CYCLES = 50_000_000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Tick
  output logic      tick
);
  initial begin
    if (CYCLES < 2) $error("ars_tick: CYCLES must be at least 2");
  end

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 32'h1;
    if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_d  = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

/* tb/ars_chk_properties.sv */
// Port-level checks for the restart supervisor
`default_nettype none
module ars_chk #(
  parameter int unsigned TICK_CYCLES_P = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Link and results
  input wire logic fault_ack,
  input wire logic run_command,
  input wire logic restart_request,
  input wire logic restart_failed_fault,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");
  a_bus_idle_wait: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_req_pulse: assert property (
    restart_request |=> !restart_request)
    else $error("restart request longer than one cycle");
  a_req_after_ack: assert property (
    $rose(restart_request) |-> $past(fault_ack))
    else $error("restart request without acknowledge");
  a_no_req_halted: assert property (
    restart_failed_fault |-> !restart_request)
    else $error("restart requested while halted");
  a_fail_holds: assert property (
    restart_failed_fault && !fault_ack |=> restart_failed_fault)
    else $error("restart failure dropped without acknowledge");
  a_fail_clears: assert property (
    restart_failed_fault && fault_ack && !run_command |=> ##[0:1] !restart_failed_fault)
    else $error("restart failure kept after acknowledge");
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst |=> !restart_request && !restart_failed_fault && !irq && avs_waitrequest)
    else $error("outputs not quiet after reset");
endmodule
bind ars_supervisor ars_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) ars_chk_inst (
  .clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .fault_ack(fault_ack), .run_command(run_command),
  .restart_request(restart_request), .restart_failed_fault(restart_failed_fault), .irq(irq));
`default_nettype wire

/* tb/ars_far.sv */
// Start sequence model: answers each restart request with a start report
`default_nettype none
module ars_far (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Restart handshake
  input  wire logic       restart_request,
  input  wire logic [2:0] delay,
  output logic            start_success
);
  logic [3:0] cnt_q;

  // Start takes a variable time, as flying start and magnetizing would
  always_ff @(posedge clk_sys) begin
    start_success <= 1'b0;
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else if (restart_request) begin
      cnt_q <= {1'b0, delay} + 4'h1;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      start_success <= (cnt_q == 4'h1);
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the restart supervisor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ars_pkg::*;
  localparam int unsigned TK = 10;
  localparam logic [7:0] MD [5] = '{MODE_4, MODE_6, MODE_14, MODE_16, MODE_26};
  logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic fault_detect = 1'b0, fault_ack = 1'b0, run_command = 1'b1, ff_q = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [15:0] fault_number = 16'h0, num;
  logic [2:0] delay = 3'h0;
  logic avs_waitrequest, start_success, restart_request, restart_failed_fault, irq;
  logic [31:0] rq[$];
  logic [1:0] eq[$];
  int fails = 0, comparisons = 0, seed = 32'h41ae7aaf;

  initial forever #10 clk_sys = ~clk_sys;

  ars_supervisor #(.TICK_CYCLES_P(TK)) ars_supervisor_inst (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_detect(fault_detect),
    .fault_number(fault_number), .fault_ack(fault_ack), .start_success(start_success),
    .run_command(run_command), .restart_request(restart_request),
    .restart_failed_fault(restart_failed_fault), .irq(irq));
  ars_far ars_far_inst (.clk_sys(clk_sys), .nrst(nrst), .restart_request(restart_request),
    .delay(delay), .start_success(start_success));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ack;
    fault_ack <= 1'b1;
    @(posedge clk_sys);
    fault_ack <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic flt(input logic [15:0] n, input logic a);
    fault_number <= n;
    fault_detect <= 1'b1;
    delay <= 3'($random(seed));
    run_command <= 1'($random(seed));
    @(posedge clk_sys);
    fault_detect <= 1'b0;
    if (a) ack;
    repeat (12) @(posedge clk_sys);
  endtask

  // Results are matched in order against what the driver announced
  always @(posedge clk_sys) begin
    if (avs_read && !avs_waitrequest) chk(avs_readdata, rq.pop_front());
    if (restart_request === 1'b1) chk(eq.size() > 0 ? eq.pop_front() : 2'h0, 32'h1);
    if (restart_failed_fault === 1'b1 && ff_q !== 1'b1)
      chk(eq.size() > 0 ? eq.pop_front() : 2'h0, 32'h2);
    ff_q <= restart_failed_fault;
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(IDX_MON_TIME, 32'h3c);
    rd(IDX_WIN_TIME, 32'h0);
    rd(IDX_MAX_ATT, 32'h3);
    bus(1'b1, 5'h07, 32'hffff_ffff);
    rd(5'h07, 32'h0);
    wr_mask: bus(1'b1, IDX_IRQ_MASK, 32'h3);
    flt(16'h0101, 1'b1);
    bus(1'b1, IDX_MON_TIME, 32'h14);
    foreach (MD[i]) begin
      bus(1'b1, IDX_CTRL, {24'h0, MD[i]});
      eq.push_back(2'h1);
      flt(16'h0100 + 16'(i), 1'b1);
    end
    chk(irq, 1'b1);
    bus(1'b1, IDX_IRQ_MASK, 32'h1);
    chk(irq, 1'b0);
    rd(IDX_IRQ_STAT, 32'h2);
    bus(1'b1, IDX_IRQ_STAT, 32'h2);
    rd(IDX_IRQ_STAT, 32'h0);
    // Monitor expiry with a two-second budget and no acknowledge
    bus(1'b1, IDX_MON_TIME, 32'h2);
    eq.push_back(2'h2);
    flt(16'h0200, 1'b0);
    repeat (30) @(posedge clk_sys);
    chk(irq, 1'b1);
    run_command <= 1'b0;
    ack;
    run_command <= 1'b1;
    chk(restart_failed_fault, 1'b0);
    bus(1'b1, IDX_IRQ_STAT, 32'h3);
    bus(1'b1, IDX_MON_TIME, 32'h0);
    flt(16'h0300, 1'b0);
    repeat (40) @(posedge clk_sys);
    eq.push_back(2'h1);
    ack;
    repeat (12) @(posedge clk_sys);
    bus(1'b1, IDX_WIN_TIME, 32'ha);
    bus(1'b1, IDX_MAX_ATT, 32'h2);
    eq.push_back(2'h1);
    flt(16'h0400, 1'b1);
    eq.push_back(2'h2);
    flt(16'h0401, 1'b1);
    run_command <= 1'b1;
    ack;
    chk(restart_failed_fault, 1'b1);
    run_command <= 1'b0;
    ack;
    run_command <= 1'b1;
    // Three starts inside one open window, two allowed: the third start halts
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, IDX_MAX_ATT, 32'h2);
      eq.push_back(2'h1);
      if (k == 2) eq.push_back(2'h2);
      flt(16'h0402, 1'b1);
    end
    rd(IDX_STATUS, 32'h40cb);
    run_command <= 1'b0;
    ack;
    run_command <= 1'b1;
    num = {1'b1, 15'($random(seed))};
    bus(1'b1, IDX_LIST0 + 5'h09, {16'h0, num});
    bus(1'b1, IDX_CTRL, {24'h0, MODE_4});
    eq.push_back(2'h1);
    flt(num, 1'b1);
    bus(1'b1, IDX_CTRL, {24'h0, MODE_6});
    flt(num, 1'b1);
    chk(32'(eq.size() + rq.size()), 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
